// ---- hdl/fsld_consts.vh ----
// Constants for the fieldbus status indicator driver
`ifndef FSLD_CONSTS_VH
`define FSLD_CONSTS_VH

// ************************************************************
// Time base
// ************************************************************
`define FSLD_CLK_NS        20
`define FSLD_TICK_NS       1000000
`define FSLD_MS_CYCLES     (`FSLD_TICK_NS / `FSLD_CLK_NS)

// ************************************************************
// Pattern phase lengths in ms
// ************************************************************
`define FSLD_FLICK_MS      11'd50
`define FSLD_SHORT_MS      11'd200
`define FSLD_LONG_MS       11'd1000

// ************************************************************
// Pattern codes
// ************************************************************
`define FSLD_PAT_OFF       3'h0
`define FSLD_PAT_ON        3'h1
`define FSLD_PAT_FLICK     3'h2
`define FSLD_PAT_BLINK     3'h3
`define FSLD_PAT_SINGLE    3'h4
`define FSLD_PAT_DOUBLE    3'h5

// ************************************************************
// Slave state machine state codes
// ************************************************************
`define FSLD_ST_INIT       4'h1
`define FSLD_ST_PREOP      4'h2
`define FSLD_ST_BOOT       4'h3
`define FSLD_ST_SAFEOP     4'h4
`define FSLD_ST_OP         4'h8

`endif

// ---- hdl/fsld_top.v ----
// Fieldbus status indicator driver: pattern timing and selection
`timescale 1ns/1ps
`include "fsld_consts.vh"
// Limitation: only the supply sense is resynchronised; all controller
// levels share this clock, so a one-cycle glitch restarts a pattern.

module fsld_top #(
   parameter MS_CYCLES = `FSLD_MS_CYCLES    // Cycles per millisecond
) (
   // Clock and reset
   input  wire       clk,
   input  wire       rst,
   // Slave state machine state
   input  wire [3:0] esm_state,
   // Error conditions
   input  wire       param_load_fail,
   input  wire       invalid_config,
   input  wire       local_error,
   input  wire       watchdog_timeout,
   input  wire       memory_error,
   input  wire       controller_active,
   // Per-port link status
   input  wire [1:0] port_open,
   input  wire [1:0] link_up,
   input  wire [1:0] activity,
   // Supply sense pin
   input  wire       power_good,
   // Indicator outputs
   output wire       run_indicator,
   output wire       fault_indicator,
   output wire [1:0] link_activity_led,
   output reg        supply_indicator
);

   // ************************************************************
   // Pattern helper functions
   // ************************************************************

   // Length of one full cycle of a pattern, in ms
   // Longest cycle is the double flash, well inside 11 bits
   function [10:0] pat_period;
      input [2:0] pat;
      begin
         case (pat)
            `FSLD_PAT_FLICK:  pat_period = `FSLD_FLICK_MS + `FSLD_FLICK_MS;
            `FSLD_PAT_BLINK:  pat_period = `FSLD_SHORT_MS + `FSLD_SHORT_MS;
            `FSLD_PAT_SINGLE: pat_period = `FSLD_SHORT_MS + `FSLD_LONG_MS;
            `FSLD_PAT_DOUBLE: pat_period = `FSLD_SHORT_MS + `FSLD_SHORT_MS +
                                           `FSLD_SHORT_MS + `FSLD_LONG_MS;
            default:          pat_period = 11'h001;  // Steady: no phase
         endcase
      end
   endfunction

   // Lit level of a pattern at a given ms position in its cycle
   function pat_lit;
      input [2:0]  pat;
      input [10:0] pos;
      begin
         case (pat)
            `FSLD_PAT_ON:     pat_lit = 1'b1;
            `FSLD_PAT_FLICK:  pat_lit = (pos < `FSLD_FLICK_MS);
            `FSLD_PAT_BLINK:  pat_lit = (pos < `FSLD_SHORT_MS);
            `FSLD_PAT_SINGLE: pat_lit = (pos < `FSLD_SHORT_MS);
            `FSLD_PAT_DOUBLE: pat_lit = (pos < `FSLD_SHORT_MS) ||
               ((pos >= `FSLD_SHORT_MS + `FSLD_SHORT_MS) &&
                (pos < `FSLD_SHORT_MS + `FSLD_SHORT_MS +
                       `FSLD_SHORT_MS));
            default:          pat_lit = 1'b0;
         endcase
      end
   endfunction

   // ************************************************************
   // Millisecond time base
   // ************************************************************
   // Divider end point; the count is held to 16 bits on purpose, which
   // covers the 50 MHz default of 50000 cycles per millisecond
   localparam [31:0] MS_WIDE   = MS_CYCLES;       // Cycles per ms, 32 bits
   localparam [15:0] TICK_LAST = MS_WIDE[15:0] - 16'h0001; // Last cycle

   reg  [15:0] tick_cnt_reg;                      // Cycle count in ms
   reg         ms_tick_reg;                       // One-cycle ms pulse

   // Shared divider so every patterned indicator stays in step
   // Tick is registered, so phase edges lag the divider by two clocks
   always @(posedge clk) begin
      if (rst) begin
         tick_cnt_reg <= 16'h0000;
         ms_tick_reg  <= 1'b0;
      end else if (tick_cnt_reg == TICK_LAST) begin
         tick_cnt_reg <= 16'h0000;
         ms_tick_reg  <= 1'b1;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 16'h0001;
         ms_tick_reg  <= 1'b0;
      end
   end

   // ************************************************************
   // Supply sense synchroniser
   // ************************************************************
   reg         pwr_meta_reg;                      // First stage only
   reg         pwr_sync_reg;                      // Safe to read

   // Supply sense is a pin, so it is resynchronised first
   // The output flop adds a third cycle of lag to the sense
   always @(posedge clk) begin
      if (rst) begin
         pwr_meta_reg     <= 1'b0;
         pwr_sync_reg     <= 1'b0;
         supply_indicator <= 1'b0;
      end else begin
         pwr_meta_reg     <= power_good;
         pwr_sync_reg     <= pwr_meta_reg;
         supply_indicator <= pwr_sync_reg;
      end
   end

   // ************************************************************
   // Pattern selection
   // ************************************************************
   reg  [2:0]  run_sel;                           // Run pattern
   reg  [2:0]  fault_sel;                         // Fault pattern
   reg  [5:0]  link_sel;                          // Two link patterns
   wire [11:0] sel_bus;                           // All selections
   integer     pi;                                // Port loop index

   // Run pattern follows the slave state
   always @* begin
      case (esm_state)
         `FSLD_ST_PREOP:  run_sel = `FSLD_PAT_BLINK;
         `FSLD_ST_SAFEOP: run_sel = `FSLD_PAT_SINGLE;
         `FSLD_ST_OP:     run_sel = `FSLD_PAT_ON;
         `FSLD_ST_BOOT:   run_sel = `FSLD_PAT_FLICK;
         default:         run_sel = `FSLD_PAT_OFF;
      endcase
   end

   // Fault pattern: the most serious condition wins
   // Memory error with an idle controller outranks all else, since
   // the controller cannot report anything finer in that case
   always @* begin
      if (memory_error && !controller_active)
         fault_sel = `FSLD_PAT_ON;
      else if (param_load_fail)
         fault_sel = `FSLD_PAT_FLICK;
      else if (watchdog_timeout)
         fault_sel = `FSLD_PAT_DOUBLE;
      else if (invalid_config)
         fault_sel = `FSLD_PAT_BLINK;
      else if (local_error)
         fault_sel = `FSLD_PAT_SINGLE;
      else
         fault_sel = `FSLD_PAT_OFF;
   end

   // Link pattern per port; no link reads as dark too
   // Activity is a raw level; each rise of it on an open, linked port restarts the flicker
   always @* begin
      link_sel = 6'h00;
      for (pi = 0; pi < 2; pi = pi + 1) begin
         if (!port_open[pi] || !link_up[pi])
            link_sel[pi*3 +: 3] = `FSLD_PAT_OFF;
         else if (activity[pi])
            link_sel[pi*3 +: 3] = `FSLD_PAT_FLICK;
         else
            link_sel[pi*3 +: 3] = `FSLD_PAT_ON;
      end
   end

   // Generator order: run, fault, link port 0, link port 1
   assign sel_bus = {link_sel, fault_sel, run_sel};

   // ************************************************************
   // Pattern generators, one per indicator except the supply indicator
   // ************************************************************
   // Each generator keeps its own ms position and pattern copy.
   // The position only moves on the shared tick, so one full ms lasts
   // exactly MS_CYCLES clocks and every phase after the first is exact.
   // Trade-off: a divider per indicator would make the first phase exact
   // too, but would cost one more counter per output.
   wire [3:0]  lit_bus;                           // Registered levels

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_ind
         wire [2:0]  sel_now = sel_bus[gi*3 +: 3];   // Wanted pattern
         reg  [2:0]  sel_reg;                        // Running pattern
         reg  [10:0] pos_reg;                        // ms in cycle
         reg         lit_reg;                        // Output level

         // Change restarts at the lit phase; first ms may be short
         // since the tick is shared rather than restarted
         always @(posedge clk) begin
            if (rst) begin
               sel_reg <= `FSLD_PAT_OFF;
               pos_reg <= 11'h000;
               lit_reg <= 1'b0;
            end else if (sel_now != sel_reg) begin
               sel_reg <= sel_now;
               pos_reg <= 11'h000;
               lit_reg <= pat_lit(sel_now, 11'h000);
            end else begin
               if (ms_tick_reg) begin
                  if (pos_reg == pat_period(sel_reg) - 11'h001)
                     pos_reg <= 11'h000;             // Cycle repeats
                  else
                     pos_reg <= pos_reg + 11'h001;
               end
               // Steady patterns wrap at one ms, so pos stays at 0
               lit_reg <= pat_lit(sel_reg, pos_reg);
            end
         end

         assign lit_bus[gi] = lit_reg;
      end
   endgenerate

   assign run_indicator     = lit_bus[0];
   assign fault_indicator   = lit_bus[1];
   assign link_activity_led = lit_bus[3:2];

endmodule // fsld_top

// ---- dv/fsld_top_props.sv ----
// Assertions on the indicator driver ports
`timescale 1ns/1ps
module fsld_props #(
   parameter MS_CYCLES = 2                // Clocks per ms, as in the DUT
) (
   // Clock and reset
   input wire       clk,
   input wire       rst,
   // Controller levels
   input wire       power_good,
   input wire       param_load_fail,
   input wire       invalid_config,
   input wire       local_error,
   input wire       watchdog_timeout,
   input wire       memory_error,
   input wire       controller_active,
   input wire [3:0] esm_state,
   input wire [1:0] port_open,
   input wire [1:0] link_up,
   input wire [1:0] activity,
   // Indicators
   input wire [1:0] link_activity_led,
   input wire       run_indicator,
   input wire       fault_indicator,
   input wire       supply_indicator
);
   reg [15:0] hi_cnt, lo_cnt, age; // Run lengths, age of the state
   // Lengths are only judged once the state has settled
   always @(posedge clk) begin
      hi_cnt <= run_indicator ? hi_cnt + 16'h1 : 16'h0;
      lo_cnt <= run_indicator ? 16'h0 : lo_cnt + 16'h1;
      age <= (rst || $changed(esm_state)) ? 16'h0 : age + {15'h0, ~&age};
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   supply_lag_a: assert property (!$past(rst) && !$past(rst, 2) &&
      !$past(rst, 3) |-> supply_indicator == $past(power_good, 3))
      else $error("supply indicator lag wrong");
   run_op_a: assert property (esm_state == 4'h8 |=> run_indicator)
      else $error("run not lit in operational");
   run_init_a: assert property (esm_state == 4'h1 |=> !run_indicator)
      else $error("run lit in init");
   preop_restart_a: assert property (esm_state == 4'h2 &&
      $past(esm_state) != 4'h2 |=> run_indicator)
      else $error("blink did not start lit");
   flick_lit_a: assert property ($fell(run_indicator) &&
      esm_state == 4'h3 && age > 100 * MS_CYCLES |-> hi_cnt == 50 * MS_CYCLES)
      else $error("flicker lit length wrong");
   single_dark_a: assert property ($rose(run_indicator) &&
      esm_state == 4'h4 && age > 16'd2 |-> lo_cnt == 1000 * MS_CYCLES)
      else $error("single flash dark length wrong");
   mem_on_a: assert property (memory_error && !controller_active
      |=> fault_indicator) else $error("fault not on for memory error");
   fault_off_a: assert property (!(param_load_fail || invalid_config ||
      local_error || watchdog_timeout || memory_error) |=> !fault_indicator)
      else $error("fault lit without error");
   link_off_a: assert property (1'b1 |=> (link_activity_led &
      ~($past(port_open) & $past(link_up))) == 2'b00)
      else $error("link lit on closed port");
   link_on_a: assert property (1'b1 |=> (~link_activity_led &
      $past(port_open) & $past(link_up) & ~$past(activity)) == 2'b00)
      else $error("idle link not lit");
endmodule // fsld_props
bind fsld_top fsld_props #(.MS_CYCLES(MS_CYCLES)) i_props (.clk(clk),
   .rst(rst), .power_good(power_good), .param_load_fail(param_load_fail),
   .invalid_config(invalid_config), .local_error(local_error),
   .watchdog_timeout(watchdog_timeout), .memory_error(memory_error),
   .controller_active(controller_active), .esm_state(esm_state),
   .port_open(port_open), .link_up(link_up), .activity(activity),
   .link_activity_led(link_activity_led), .run_indicator(run_indicator),
   .fault_indicator(fault_indicator), .supply_indicator(supply_indicator));

// ---- dv/fsld_ctrl_model.sv ----
// Slave controller model: state and status levels
`timescale 1ns/1ps
module fsld_ctrl_model (
   // Command word from the bench
   input  wire [16:0] cmd,
   // Levels towards the driver
   output wire [3:0]  esm_state,
   output wire        param_load_fail,
   output wire        invalid_config,
   output wire        local_error,
   output wire        watchdog_timeout,
   output wire        memory_error,
   output wire        controller_active,
   output wire [1:0]  port_open,
   output wire [1:0]  link_up,
   output wire [1:0]  activity,
   output wire        power_good
);
   // Plain levels, no handshake exists on this side
   assign {esm_state, param_load_fail, invalid_config, local_error,
           watchdog_timeout, memory_error, controller_active,
           port_open, link_up, activity, power_good} = cmd;
endmodule // fsld_ctrl_model

// ---- dv/tb_fieldbus_status_led_driver.sv ----
// Self-checking bench of the indicator driver
`timescale 1ns/1ps
module tb_fieldbus_status_led_driver;
   localparam MS = 2;                  // Shortened millisecond
   reg        clk = 1'b0, rst = 1'b1;
   reg [16:0] cmd = 17'h0;             // Controller command word
   wire [3:0] esm;
   wire       pl, ic, le, wd, me, ca, pg, run, flt, sup;
   wire [1:0] po, lu, act, led;
   integer    fails = 0, n_tests = 0;
   always #10 clk = ~clk;
   fsld_ctrl_model i_ctrl (.cmd(cmd), .esm_state(esm), .param_load_fail(pl),
      .invalid_config(ic), .local_error(le), .watchdog_timeout(wd),
      .memory_error(me), .controller_active(ca), .port_open(po),
      .link_up(lu), .activity(act), .power_good(pg));
   fsld_top #(.MS_CYCLES(MS)) i_dut (.clk(clk), .rst(rst), .esm_state(esm),
      .param_load_fail(pl), .invalid_config(ic), .local_error(le),
      .watchdog_timeout(wd), .memory_error(me), .controller_active(ca),
      .port_open(po), .link_up(lu), .activity(act), .power_good(pg),
      .run_indicator(run), .fault_indicator(flt),
      .link_activity_led(led), .supply_indicator(sup));
   task end_sim;
      begin
         if (fails == 0 && n_tests > 0) $display("verification passed");
         else $display("verification failed");
         $finish;
      end
   endtask
   task chk(input [15:0] got, input [15:0] exp);
      begin
         n_tests = n_tests + 1;
         if (got !== exp) begin
            fails = fails + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   function sig(input [1:0] sel);
      sig = sel == 2'd0 ? run : sel == 2'd1 ? flt : led[sel[0]];
   endfunction
   // Length of the run at one level, bounded
   task run_len(input [1:0] sel, input lvl, output [15:0] n);
      begin
         n = 16'h0;
         while (sig(sel) === lvl && n < 16'd5000) begin
            @(negedge clk);
            n = n + 16'h1;
         end
         if (n >= 16'd5000) begin
            chk(n, 16'h0);
            end_sim;
         end
      end
   endtask
   // Apply a command, judge first level then phase lengths
   task check_pat(input [16:0] c, input [1:0] sel, input [2:0] code);
      reg [15:0] n;
      reg [63:0] tab;
      integer    i;
      begin
         cmd = c;
         @(negedge clk);
         chk(sig(sel), code != 3'h0);
         n = 16'h0;
         if (code < 3'h2) begin
            for (i = 0; i < 2500; i = i + 1) begin
               @(negedge clk);
               if (sig(sel) !== (code == 3'h1)) n = n + 16'h1;
            end
            chk(n, 16'h0);
         end else begin
            case (code)
               3'h2: tab = {4{16'd50}};
               3'h3: tab = {4{16'd200}};
               3'h4: tab = {16'd1000, 16'd200, 16'd1000, 16'd200};
               default: tab = {16'd200, 16'd200, 16'd1000, 16'd200};
            endcase
            run_len(sel, 1'b1, n);
            for (i = 0; i < 4; i = i + 1) begin
               run_len(sel, i[0], n);
               chk(n, tab[63-16*i -: 16] * MS);
            end
         end
      end
   endtask
   // Supply lag, then a reset in mid-run
   task t_supply;
      begin
         cmd = {4'h8, 13'h0};
         repeat (4) @(negedge clk);
         chk(sup, 1'b0);
         cmd[0] = 1'b1;
         repeat (2) @(negedge clk);
         chk(sup, 1'b0);
         @(negedge clk);
         chk({run, sup}, 2'b11);
         rst = 1'b1;
         repeat (2) @(negedge clk);
         chk({run, sup}, 2'b00);
         rst = 1'b0;
      end
   endtask
   task t_run;
      begin
         check_pat({4'h1, 13'h1}, 2'd0, 3'h0);
         check_pat({4'h2, 13'h1}, 2'd0, 3'h3);
         check_pat({4'h4, 13'h1}, 2'd0, 3'h4);
         check_pat({4'h8, 13'h1}, 2'd0, 3'h1);
         check_pat({4'h3, 13'h1}, 2'd0, 3'h2);
         check_pat({4'hf, 13'h1}, 2'd0, 3'h0);
      end
   endtask
   // Fault sources, including overlapping ones
   task t_fault;
      begin
         check_pat({4'h0, 6'b100000, 7'h1}, 2'd1, 3'h2);
         check_pat({4'h0, 6'b011000, 7'h1}, 2'd1, 3'h3);
         check_pat({4'h0, 6'b001000, 7'h1}, 2'd1, 3'h4);
         check_pat({4'h0, 6'b011100, 7'h1}, 2'd1, 3'h5);
         check_pat({4'h0, 6'b100010, 7'h1}, 2'd1, 3'h1);
         check_pat({4'h0, 6'b000011, 7'h1}, 2'd1, 3'h0);
         check_pat({4'h0, 6'b000000, 7'h1}, 2'd1, 3'h0);
      end
   endtask
   // Each port alone, the other port closed
   task t_link;
      reg [1:0] p, b;
      begin
         for (p = 2'd0; p < 2'd2; p = p + 2'd1) begin
            b = p[0] ? 2'b10 : 2'b01;
            check_pat({10'h0, b, 2'b00, b, 1'b1}, {1'b1, p[0]}, 3'h0);
            check_pat({10'h0, 2'b00, b, b, 1'b1}, {1'b1, p[0]}, 3'h0);
            check_pat({10'h0, b, b, b, 1'b1}, {1'b1, p[0]}, 3'h2);
            check_pat({10'h0, b, b, 2'b00, 1'b1}, {1'b1, p[0]}, 3'h1);
         end
      end
   endtask
   initial begin
      repeat (5) @(negedge clk);
      rst = 1'b0;
      t_supply;
      t_run;
      t_fault;
      t_link;
      end_sim;
   end
endmodule // tb_fieldbus_status_led_driver
